// ---- verilog/sdac_params.svh ----
// constants for the serial dac load logic
// Summary of operation
// - frame select is active low, frames words
// - frame select low enables shift register
// - shift one bit per falling serial clock
// - input shift register is eight bits
// - frame is eight falling clock edges
// - load falling edge copies shift register
// - load held low: update after eight edges
// - latch code is straight binary 0..255
`ifndef SDAC_PARAMS_SVH
`define SDAC_PARAMS_SVH

// ----------------------------------------
// widths and counts
// ----------------------------------------
`define SDAC_WORD_W      8
`define SDAC_CNT_W       4
`define SDAC_FRAME_BITS  4'h8
`define SDAC_CNT_ZERO    4'h0
`define SDAC_CNT_ONE     4'h1
`define SDAC_WORD_ZERO   8'h00

`endif

// ---- verilog/sdac_pkg.sv ----
// types for the serial dac load logic
package sdac_pkg;
    typedef enum logic [1:0] {
        SDAC_IDLE,
        SDAC_SHIFT,
        SDAC_FULL
    } sdac_state_type;
endpackage

// ---- verilog/sdac_sync.sv ----
// two-flop synchroniser with level and falling-edge outputs for one pin
module sdac_sync (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      fall_o
);
    logic meta_r;
    logic sync_r;
    logic prev_r;
    logic meta_nxt;
    logic sync_nxt;
    logic prev_nxt;

    always_comb begin
        meta_nxt = pin_i;
        sync_nxt = meta_r;
        prev_nxt = sync_r;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            prev_r <= 1'b1;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            prev_r <= prev_nxt;
        end
    end

    assign level_o = sync_r;
    assign fall_o  = prev_r & ~sync_r;
endmodule

// ---- verilog/sdac_load.sv ----
// serial load logic of an eight-bit multiplying dac
`include "sdac_params.svh"

module sdac_load (
    // clock and reset
    input  wire logic                     CLK_SYS_I,
    input  wire logic                     NRST_I,
    // serial link
    input  wire logic                     FRAME_SEL_N_I,
    input  wire logic                     SCLK_I,
    input  wire logic                     SERIAL_DATA_IN_I,
    input  wire logic                     LOAD_OUTPUT_N_I,
    // converter side
    output logic [`SDAC_WORD_W-1:0]       DAC_CODE_O,
    output logic [`SDAC_WORD_W-1:0]       SHIFT_REG_O,
    output logic                          INPUT_EN_O
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic sel_lvl;
    logic sel_fall;
    logic sclk_fall;
    logic load_lvl;
    logic load_fall;
    logic data_lvl;

    sdac_sync u_sel (
        .clk_i   (CLK_SYS_I),
        .nrst_i  (NRST_I),
        .pin_i   (FRAME_SEL_N_I),
        .level_o (sel_lvl),
        .fall_o  (sel_fall)
    );
    sdac_sync u_sclk (
        .clk_i   (CLK_SYS_I),
        .nrst_i  (NRST_I),
        .pin_i   (SCLK_I),
        .level_o (),
        .fall_o  (sclk_fall)
    );
    sdac_sync u_load (
        .clk_i   (CLK_SYS_I),
        .nrst_i  (NRST_I),
        .pin_i   (LOAD_OUTPUT_N_I),
        .level_o (load_lvl),
        .fall_o  (load_fall)
    );
    sdac_sync u_data (
        .clk_i   (CLK_SYS_I),
        .nrst_i  (NRST_I),
        .pin_i   (SERIAL_DATA_IN_I),
        .level_o (data_lvl),
        .fall_o  ()
    );

    // ----------------------------------------
    // frame state, shifter and latch
    // ----------------------------------------
    sdac_pkg::sdac_state_type     state_r;
    sdac_pkg::sdac_state_type     state_nxt;
    logic [`SDAC_CNT_W-1:0]       cnt_r;
    logic [`SDAC_CNT_W-1:0]       cnt_nxt;
    logic [`SDAC_WORD_W-1:0]      shift_r;
    logic [`SDAC_WORD_W-1:0]      shift_nxt;
    logic [`SDAC_WORD_W-1:0]      latch_r;
    logic [`SDAC_WORD_W-1:0]      latch_nxt;
    logic                         en_r;
    logic                         en_nxt;
    logic                         take;

    // the count at which the eighth bit of a frame arrives
    function automatic logic last_bit(input logic [`SDAC_CNT_W-1:0] cnt);
        return (cnt == `SDAC_FRAME_BITS - `SDAC_CNT_ONE);
    endfunction

    // a bit is taken on a falling serial clock inside an open frame until its eighth bit is in
    assign take = sclk_fall & ~sel_lvl & (state_r == sdac_pkg::SDAC_SHIFT);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        shift_nxt = shift_r;
        latch_nxt = latch_r;
        en_nxt    = en_r;
        case (state_r)
            sdac_pkg::SDAC_IDLE: begin
                en_nxt = 1'b0;
                if (sel_fall) begin
                    state_nxt = sdac_pkg::SDAC_SHIFT;
                    cnt_nxt   = `SDAC_CNT_ZERO;
                    en_nxt    = 1'b1;
                end
            end
            sdac_pkg::SDAC_SHIFT: begin
                if (sel_lvl) begin
                    state_nxt = sdac_pkg::SDAC_IDLE;
                    en_nxt    = 1'b0;
                end else if (take) begin
                    // msb first, shifting toward the top
                    shift_nxt = {shift_r[`SDAC_WORD_W-2:0], data_lvl};
                    cnt_nxt   = cnt_r + `SDAC_CNT_ONE;
                    if (last_bit(cnt_r)) begin
                        state_nxt = sdac_pkg::SDAC_FULL;
                        en_nxt    = 1'b0;
                    end
                end
            end
            sdac_pkg::SDAC_FULL: begin
                // further edges ignored until the frame closes
                en_nxt = 1'b0;
                if (sel_lvl) begin
                    state_nxt = sdac_pkg::SDAC_IDLE;
                end
            end
            default: begin
                state_nxt = sdac_pkg::SDAC_IDLE;
                en_nxt    = 1'b0;
            end
        endcase
        // straight binary code to the ladder
        if (load_fall) begin
            latch_nxt = shift_r;
        end else if (!load_lvl && take &&
                     last_bit(cnt_r)) begin
            latch_nxt = {shift_r[`SDAC_WORD_W-2:0], data_lvl};
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state_r <= sdac_pkg::SDAC_IDLE;
            cnt_r   <= `SDAC_CNT_ZERO;
            shift_r <= `SDAC_WORD_ZERO;
            latch_r <= `SDAC_WORD_ZERO;
            en_r    <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            shift_r <= shift_nxt;
            latch_r <= latch_nxt;
            en_r    <= en_nxt;
        end
    end

    assign DAC_CODE_O  = latch_r;
    assign SHIFT_REG_O = shift_r;
    assign INPUT_EN_O  = en_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_load_copy;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        load_fall |=> (latch_r == $past(shift_r));
    endproperty
    a_load_copy: assert property (p_load_copy)
        else $error("latch missed load edge");

    property p_auto;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        (!load_lvl && take && last_bit(cnt_r) && !load_fall)
            |=> (latch_r == shift_r);
    endproperty
    a_auto: assert property (p_auto)
        else $error("auto update missed");

    property p_shift;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        take |=> (shift_r[0] == $past(data_lvl));
    endproperty
    a_shift: assert property (p_shift)
        else $error("bit not shifted in");

    property p_count;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        (state_r == sdac_pkg::SDAC_FULL) |-> (cnt_r == `SDAC_FRAME_BITS);
    endproperty
    a_count: assert property (p_count)
        else $error("frame full without eight bits");

    property p_open;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        (state_r == sdac_pkg::SDAC_IDLE && sel_fall) |=> en_r;
    endproperty
    a_open: assert property (p_open)
        else $error("input not enabled on select");

    property p_close;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        (sel_lvl && state_r != sdac_pkg::SDAC_IDLE)
            |=> (state_r == sdac_pkg::SDAC_IDLE) && !en_r;
    endproperty
    a_close: assert property (p_close)
        else $error("frame not closed on select high");

    property p_hold;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        !sclk_fall |=> $stable(shift_r);
    endproperty
    a_hold: assert property (p_hold)
        else $error("shift register changed without clock");

    property p_latch_stable;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        (!load_fall && !take) |=> $stable(latch_r);
    endproperty
    a_latch_stable: assert property (p_latch_stable)
        else $error("latch changed without load");

    property p_full_ignore;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        (state_r == sdac_pkg::SDAC_FULL) |=> $stable(shift_r);
    endproperty
    a_full_ignore: assert property (p_full_ignore)
        else $error("edge after eighth bit was shifted");

    property p_load_high;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        load_lvl |=> $stable(latch_r);
    endproperty
    a_load_high: assert property (p_load_high)
        else $error("latch changed with load high");
endmodule

// ---- verification/sdac_host.sv ----
// host serial port model driving the dac load pins
module sdac_host (
    input  wire logic clk_i,
    output logic      frame_sel_n_o,
    output logic      sclk_o,
    output logic      data_o,
    output logic      load_n_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        frame_sel_n_o = 1'b1;
        sclk_o        = 1'b1;
        data_o        = 1'b0;
        load_n_o      = 1'b1;
    end

    task automatic open_frame();
        frame_sel_n_o <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask

    // bits go out from bit 9 down, n of them
    task automatic shift_bits(input logic [9:0] bits, input int n);
        for (int i = 9; i > 9 - n; i--) begin
            data_o <= bits[i];
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b0;
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b1;
        end
        repeat (4) @(posedge clk_i);
    endtask

    // released data line shows the inverse of its last bit
    task automatic close_frame();
        data_o        <= ~data_o;
        frame_sel_n_o <= 1'b1;
        repeat (10) @(posedge clk_i);
    endtask

    task automatic pulse_load();
        load_n_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        load_n_o <= 1'b1;
        repeat (8) @(posedge clk_i);
    endtask

    task automatic set_load(input logic v);
        load_n_o <= v;
        repeat (8) @(posedge clk_i);
    endtask
endmodule

// ---- verification/sdac_load_bench.sv ----
// self-checking bench for the serial dac load logic
`include "sdac_params.svh"
module sdac_load_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic                    clk;
    logic                    nrst_n;
    logic                    fs_n;
    logic                    sclk;
    logic                    sdata;
    logic                    ld_n;
    logic                    en;
    logic [`SDAC_WORD_W-1:0] code;
    logic [`SDAC_WORD_W-1:0] shreg;
    logic [`SDAC_WORD_W-1:0] prev = 8'h00;
    logic [7:0]              exp_q[$];
    int                      num_errors = 0;
    int                      n_tests = 0;

    sdac_host u_host (.clk_i(clk), .frame_sel_n_o(fs_n), .sclk_o(sclk),
                      .data_o(sdata), .load_n_o(ld_n));

    sdac_load DUT (.CLK_SYS_I(clk), .NRST_I(nrst_n), .FRAME_SEL_N_I(fs_n),
                   .SCLK_I(sclk), .SERIAL_DATA_IN_I(sdata),
                   .LOAD_OUTPUT_N_I(ld_n), .DAC_CODE_O(code),
                   .SHIFT_REG_O(shreg), .INPUT_EN_O(en));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("errors=%0d checks=%0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // every code change must match the oldest expected word
    always @(negedge clk) begin
        if (nrst_n === 1'b1 && code !== prev) begin
            if (exp_q.size() == 0) begin
                cmp8(code, prev);
            end else begin
                cmp8(code, exp_q.pop_front());
            end
        end
        prev = code;
    end

    initial begin
        #1ms;
        num_errors++;
        close_out();
    end

    initial begin
        logic [7:0] w;
        logic [7:0] last;
        void'($urandom(64159));
        nrst_n = 1'b0;
        repeat (12) @(posedge clk);
        nrst_n <= 1'b1;
        repeat (2) @(posedge clk);
        cmp8(code, 8'h00);
        cmp8(shreg, 8'h00);
        last = 8'h00;
        for (int k = 0; k < 16; k++) begin
            w = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($urandom);
            if (w == last) w = w ^ 8'h5a;
            if (k == 8) u_host.set_load(1'b0);
            u_host.open_frame();
            cmp1(en, 1'b1);
            if (k >= 8) exp_q.push_back(w);
            // odd frames carry two extra edges that must be ignored
            u_host.shift_bits({w, 2'(k)}, (k % 2 == 1) ? 10 : 8);
            u_host.close_frame();
            cmp8(shreg, w);
            cmp1(en, 1'b0);
            if (k < 8) begin
                exp_q.push_back(w);
                u_host.pulse_load();
            end
            last = w;
        end
        u_host.set_load(1'b1);
        // a frame cut after three bits leaves a partial shift
        w = 8'($urandom);
        u_host.open_frame();
        cmp1(en, 1'b1);
        u_host.shift_bits({w, 2'b00}, 3);
        u_host.close_frame();
        cmp8(shreg, {last[4:0], w[7:5]});
        cmp1(en, 1'b0);
        nrst_n <= 1'b0;
        repeat (2) @(posedge clk);
        nrst_n <= 1'b1;
        repeat (2) @(posedge clk);
        cmp8(code, 8'h00);
        cmp8(shreg, 8'h00);
        cmp8(8'(exp_q.size()), 8'h00);
        close_out();
    end
endmodule
